// File: bench/block_source.sv
/*
  Blocking matrix model: drives the stage's block input.
  Assumes the bench asks for blocking about half a program cycle ahead of the tick.
*/
`timescale 1ns/1ps
`default_nettype none
module block_source (
  input  wire logic core_clk_i,
  input  wire logic rst_i,
  input  wire logic want_i,
  output logic      block_o
);
  // registered like a matrix output, changes just after an edge
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      block_o <= 1'b0;
    end else begin
      block_o <= want_i;
    end
  end
endmodule
`default_nettype wire

// File: bench/tb_top.sv
/*
  Bench for sequence_voltage_stage: register reads, table of cases, then hand tests.
  Assumes seq_stage_pkg and the partner model are compiled first.
*/
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  localparam int CC = 128;
  logic        clk = 1'b0, rst = 1'b1, wr = 1'b0, rd = 1'b0, want = 1'b0, blk, st, tr, bk;
  logic [7:0]  adr = '0;
  logic [31:0] wd = '0, rdat, q;
  logic [15:0] meas = '0, minl = '0;
  int          err_total = 0, tests_run = 0;
  typedef struct {logic [7:0] c; logic [15:0] ub; logic [18:0] dl; logic [15:0] m; logic b; int n; logic [2:0] e;} row_s;
  row_s rows[7];

  always #12.5 clk = ~clk;

  sequence_voltage_stage #(.CYCLE_CLKS(CC)) dut (.core_clk_i(clk), .rst_i(rst), .addr_i(adr), .wdata_i(wd),
    .wr_i(wr), .rd_i(rd), .rdata_o(rdat), .meas_i(meas), .min_line_i(minl), .block_i(blk),
    .start_o(st), .trip_o(tr), .blocked_o(bk));
  block_source partner (.core_clk_i(clk), .rst_i(rst), .want_i(want), .block_o(blk));

  // ---------------------------------------------------------------
  // tasks
  // ---------------------------------------------------------------
  task automatic chk(string nm, logic [31:0] e, logic [31:0] s);
    tests_run++;
    if (s !== e) begin
      err_total++;
      $display("wrong value %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic tk(int n);
    repeat (n * CC) @(posedge clk);
  endtask
  task automatic w(logic [7:0] a, logic [31:0] d);
    @(posedge clk);
    wr <= 1'b1; adr <= a; wd <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic r(logic [7:0] a);
    @(posedge clk);
    rd <= 1'b1; adr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1 q = rdat;
  endtask
  task automatic o(logic [2:0] e);
    #1 chk("start_trip_blocked", {29'h0, e}, {29'h0, st, tr, bk});
  endtask
  // reset, then sit half a program cycle off the tick
  task automatic rs();
    rst <= 1'b1; meas <= '0; minl <= '0; want <= 1'b0;
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    repeat (CC / 2) @(posedge clk);
  endtask
  task automatic results();
    $display("tests run %0d, mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // ---------------------------------------------------------------
  // sequence
  // ---------------------------------------------------------------
  initial begin
    #2000000;
    err_total++;
    results();
  end

  initial begin
    rows = '{'{8'h0c, 16'h01f4, 19'h2, 16'h2af8, 1'b0, 1, 3'b100},
             '{8'h0c, 16'h01f4, 19'h2, 16'h2af8, 1'b0, 3, 3'b110},
             '{8'h0c, 16'h01f4, 19'h0, 16'h2af8, 1'b0, 1, 3'b110},
             '{8'h0c, 16'h01f4, 19'h2, 16'h2af8, 1'b1, 2, 3'b001},
             '{8'h0d, 16'h01f4, 19'h0, 16'h1388, 1'b0, 1, 3'b110},
             '{8'h0d, 16'h01f4, 19'h0, 16'h0064, 1'b0, 2, 3'b100},
             '{8'h0d, 16'h0000, 19'h0, 16'h0064, 1'b0, 2, 3'b110}};
    rs();
    r(seq_stage_pkg::ADDR_CTRL); chk("ctrl", 32'h0c, q);
    r(seq_stage_pkg::ADDR_U_SET); chk("u_set", 32'h2904, q);
    r(seq_stage_pkg::ADDR_DEF_DELAY); chk("def_delay", 32'h8, q);
    r(seq_stage_pkg::ADDR_REL_DELAY); chk("rel_delay", 32'hc, q);
    r(8'h3c); chk("unmapped", 32'h0, q);
    $display("register test done");
    foreach (rows[i]) begin
      rs();
      w(seq_stage_pkg::ADDR_CTRL, {24'h0, rows[i].c});
      w(seq_stage_pkg::ADDR_U_BLK, {16'h0, rows[i].ub});
      w(seq_stage_pkg::ADDR_DEF_DELAY, {13'h0, rows[i].dl});
      meas <= rows[i].m; want <= rows[i].b;
      tk(rows[i].n);
      o(rows[i].e);
      $display("row %0d done", i);
    end
    rs(); w(seq_stage_pkg::ADDR_CTRL, 32'h0d); w(seq_stage_pkg::ADDR_DEF_DELAY, 32'h0); meas <= 16'h0064;
    tk(2); o(3'b100);
    meas <= 16'h1388; tk(2); o(3'b100);
    minl <= 16'h2af8; tk(2); o(3'b110);
    $display("under block test done");
    rs(); w(seq_stage_pkg::ADDR_DEF_DELAY, 32'h64); meas <= 16'h2af8;
    tk(2); o(3'b100);
    r(seq_stage_pkg::ADDR_REMAINING); chk("remaining", 32'h62, q);
    want <= 1'b1; tk(2); o(3'b101);
    tk(12); o(3'b001);
    $display("late block test done");
    rs(); w(seq_stage_pkg::ADDR_CTRL, 32'h08); w(seq_stage_pkg::ADDR_DEF_DELAY, 32'h64); meas <= 16'h2af8;
    tk(1); o(3'b100);
    want <= 1'b1; tk(1); o(3'b001);
    $display("instant release test done");
    rs(); w(seq_stage_pkg::ADDR_CTRL, 32'h1c); w(seq_stage_pkg::ADDR_DEF_DELAY, 32'h4); meas <= 16'h2af8;
    tk(2); meas <= 16'h0000; tk(4); o(3'b100);
    meas <= 16'h2af8; tk(1); o(3'b110);
    $display("continue test done");
    rs(); w(seq_stage_pkg::ADDR_DEF_DELAY, 32'h0); meas <= 16'h2af8;
    tk(1); meas <= 16'h283c; tk(2); o(3'b110);
    meas <= 16'h2710; tk(1); o(3'b100);
    $display("hysteresis test done");
    rs(); w(seq_stage_pkg::ADDR_CTRL, 32'h0e); meas <= 16'h5208;
    tk(2); r(seq_stage_pkg::ADDR_EXPECTED); chk("expected", 32'ha, q);
    meas <= 16'h7b0c; tk(2); r(seq_stage_pkg::ADDR_EXPECTED); chk("expected", 32'h5, q);
    $display("inverse test done");
    results();
  end
endmodule
`default_nettype wire

// File: shared/seq_stage_pkg.sv
/*
  Constants for the sequence voltage stage: register map, field positions,
  values after reset, program-cycle timing and fixed-point scaling.
  Assumes a 40 MHz core clock and settings held in 5 ms steps.
*/
package seq_stage_pkg;

  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int CLK_FREQ_HZ     = 32'h0262_5a00;
  localparam int HZ_PER_MHZ      = 32'h000f_4240;
  localparam int PROG_CYCLE_US   = 32'h0000_1388;
  localparam int PROG_CYCLE_CLKS = (CLK_FREQ_HZ / HZ_PER_MHZ) * PROG_CYCLE_US;
  localparam int K_UNIT_US       = 32'h0000_2710;
  localparam int K_CYCLES_UNIT   = K_UNIT_US / PROG_CYCLE_US;

  // ---------------------------------------------------------------
  // widths, fixed point, hysteresis
  // ---------------------------------------------------------------
  localparam int          OP_W         = 19;
  localparam logic [18:0] OP_MAX       = 19'h7_ffff;
  localparam logic [31:0] FX_ONE       = 32'h0001_0000;
  localparam logic [31:0] FX_MAX       = 32'h0100_0000;
  localparam logic [11:0] EXP_UNIT     = 12'h064;
  localparam logic [7:0]  PCT_FULL     = 8'h64;
  localparam logic [7:0]  PCT_OVER_DRP = 8'h61;
  localparam logic [7:0]  PCT_UNDR_DRP = 8'h67;

  // ---------------------------------------------------------------
  // register offsets
  // ---------------------------------------------------------------
  localparam logic [7:0] ADDR_CTRL      = 8'h00;
  localparam logic [7:0] ADDR_U_SET     = 8'h04;
  localparam logic [7:0] ADDR_U_BLK     = 8'h08;
  localparam logic [7:0] ADDR_DEF_DELAY = 8'h0c;
  localparam logic [7:0] ADDR_DIAL_K    = 8'h10;
  localparam logic [7:0] ADDR_EXP_A     = 8'h14;
  localparam logic [7:0] ADDR_REL_DELAY = 8'h18;
  localparam logic [7:0] ADDR_STATUS    = 8'h20;
  localparam logic [7:0] ADDR_EXPECTED  = 8'h24;
  localparam logic [7:0] ADDR_REMAINING = 8'h28;

  // ---------------------------------------------------------------
  // control fields and values after reset
  // ---------------------------------------------------------------
  localparam int CTRL_UNDER_BIT    = 0;
  localparam int CTRL_INVERSE_BIT  = 1;
  localparam int CTRL_DLY_REL_BIT  = 2;
  localparam int CTRL_RST_AFT_BIT  = 3;
  localparam int CTRL_CONTINUE_BIT = 4;

  localparam logic        CTRL_UNDER_RST    = 1'b0;
  localparam logic        CTRL_INVERSE_RST  = 1'b0;
  localparam logic        CTRL_DLY_REL_RST  = 1'b1;
  localparam logic        CTRL_RST_AFT_RST  = 1'b1;
  localparam logic        CTRL_CONTINUE_RST = 1'b0;
  localparam logic [15:0] U_SET_RST         = 16'h2904;
  localparam logic [15:0] U_BLK_RST         = 16'h01f4;
  localparam logic [18:0] DEF_DELAY_RST     = 19'h0_0008;
  localparam logic [12:0] DIAL_K_RST        = 13'h0005;
  localparam logic [11:0] EXP_A_RST         = 12'h064;
  localparam logic [14:0] REL_DELAY_RST     = 15'h000c;

endpackage

// File: src/sequence_voltage_stage.sv
/*
  Timing and decision logic of one sequence voltage protection stage:
  pick-up with hysteresis, external and undervoltage blocking, instant,
  fixed-delay and inverse-time operation, configurable release.
  Assumes the measured sequence voltage, the lowest line voltage and the
  blocking input come from logic on the same clock, voltages in 0.01 %Un.
*/
// The address map and strobed register access are this design's own decisions.
// How it works
// - under mode with nonzero block level: no trip while voltage is below it
// - under-blocking holds until all line voltages exceed the pick-up level
// - block level zero switches undervoltage blocking off
// - blocking input is sampled at each program cycle before pick-up is judged
// - pick-up without blocking raises START and starts the operate timer
// - pick-up with blocking raises BLOCKED only, no START or TRIP
// - blocking after START acts like a pick-up drop, release handling applies
// - instant operation trips in the same cycle as START
// - fixed delay trips after the delay of continuous pick-up
// - inverse time is k/((Um/Us)^a-1) over, k/(1-(Um/Us)^a) under
// - delay type selects fixed or inverse time, fixed after reset
// - fixed delay in 5 ms steps up to 1800 s, default 40 ms, zero instant
// - inverse time uses dial k default 0.05 and exponent a default 1.00
// - release delay in 5 ms steps, default 60 ms, holds START meanwhile
// - delayed release clears START after release delay, else at once
// - timer clears after undisturbed release delay, or at once if disabled
// - continue option keeps the operate timer counting during release
// - continue option never trips unless pick-up returns in time
// - remaining time to trip readable in 5 ms steps, counting down
// - inverse expected time is recomputed as the voltage changes
// - over mode drops pick-up below 97 % of the set level
// - under mode drops pick-up above 103 % of the set level
`timescale 1ns/1ps
`default_nettype none
module sequence_voltage_stage #(
  parameter int unsigned CYCLE_CLKS = seq_stage_pkg::PROG_CYCLE_CLKS
) (
  input  wire logic        core_clk_i,
  input  wire logic        rst_i,
  input  wire logic [7:0]  addr_i,
  input  wire logic [31:0] wdata_i,
  input  wire logic        wr_i,
  input  wire logic        rd_i,
  output logic      [31:0] rdata_o,
  input  wire logic [15:0] meas_i,
  input  wire logic [15:0] min_line_i,
  input  wire logic        block_i,
  output logic             start_o,
  output logic             trip_o,
  output logic             blocked_o
);

  localparam int OPW = seq_stage_pkg::OP_W;
  localparam int TW  = $clog2(CYCLE_CLKS);

  typedef enum logic [1:0] {C_IDLE, C_RATIO, C_POW, C_DIV} calc_state_e;

  // ---------------------------------------------------------------
  // functions
  // ---------------------------------------------------------------
  function automatic logic [23:0] scaled(input logic [15:0] v, input logic [7:0] pct);
    scaled = 24'(v) * 24'(pct);
  endfunction

  function automatic logic [OPW-1:0] sat_inc(input logic [OPW-1:0] v);
    sat_inc = (v == seq_stage_pkg::OP_MAX) ? v : OPW'(v + 1'b1);
  endfunction

  function automatic logic [31:0] sat_mul(input logic [31:0] a, input logic [31:0] b);
    logic [63:0] pr;
    pr = 64'(a) * 64'(b);
    sat_mul = (pr[63:16] > 48'(seq_stage_pkg::FX_MAX)) ? seq_stage_pkg::FX_MAX : pr[47:16];
  endfunction

  // fractional part of the exponent by linear interpolation
  function automatic logic [31:0] frac_adj(input logic [31:0] p, input logic [31:0] x, input logic [6:0] f);
    logic signed [63:0] d;
    logic signed [63:0] corr;
    logic signed [63:0] res;
    d    = $signed(64'(x)) - $signed(64'(seq_stage_pkg::FX_ONE));
    corr = ($signed(64'(p)) * d) >>> 16;
    corr = (corr * $signed(64'(f))) / $signed(64'(seq_stage_pkg::PCT_FULL));
    res  = $signed(64'(p)) + corr;
    if (res < 0) begin
      frac_adj = 32'h0;
    end else if (res > $signed(64'(seq_stage_pkg::FX_MAX))) begin
      frac_adj = seq_stage_pkg::FX_MAX;
    end else begin
      frac_adj = res[31:0];
    end
  endfunction

  // ---------------------------------------------------------------
  // program cycle tick
  // ---------------------------------------------------------------
  logic [TW-1:0] tick_cnt;
  logic          tick;

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      tick_cnt <= '0;
      tick     <= 1'b0;
    end else if (tick_cnt == TW'(CYCLE_CLKS - 1)) begin
      tick_cnt <= '0;
      tick     <= 1'b1;
    end else begin
      tick_cnt <= TW'(tick_cnt + 1'b1);
      tick     <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // settings
  // ---------------------------------------------------------------
  logic           cfg_under;
  logic           cfg_inverse;
  logic           cfg_delayed;
  logic           cfg_rst_after;
  logic           cfg_continue;
  logic [15:0]    u_set;
  logic [15:0]    u_blk;
  logic [OPW-1:0] def_delay;
  logic [12:0]    dial_k;
  logic [11:0]    exp_a;
  logic [14:0]    rel_delay;

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      cfg_under     <= seq_stage_pkg::CTRL_UNDER_RST;
      cfg_inverse   <= seq_stage_pkg::CTRL_INVERSE_RST;
      cfg_delayed   <= seq_stage_pkg::CTRL_DLY_REL_RST;
      cfg_rst_after <= seq_stage_pkg::CTRL_RST_AFT_RST;
      cfg_continue  <= seq_stage_pkg::CTRL_CONTINUE_RST;
      u_set         <= seq_stage_pkg::U_SET_RST;
      u_blk         <= seq_stage_pkg::U_BLK_RST;
      def_delay     <= seq_stage_pkg::DEF_DELAY_RST;
      dial_k        <= seq_stage_pkg::DIAL_K_RST;
      exp_a         <= seq_stage_pkg::EXP_A_RST;
      rel_delay     <= seq_stage_pkg::REL_DELAY_RST;
    end else if (wr_i) begin
      case (addr_i)
        seq_stage_pkg::ADDR_CTRL: begin
          cfg_under     <= wdata_i[seq_stage_pkg::CTRL_UNDER_BIT];
          cfg_inverse   <= wdata_i[seq_stage_pkg::CTRL_INVERSE_BIT];
          cfg_delayed   <= wdata_i[seq_stage_pkg::CTRL_DLY_REL_BIT];
          cfg_rst_after <= wdata_i[seq_stage_pkg::CTRL_RST_AFT_BIT];
          cfg_continue  <= wdata_i[seq_stage_pkg::CTRL_CONTINUE_BIT];
        end
        seq_stage_pkg::ADDR_U_SET:     u_set     <= wdata_i[15:0];
        seq_stage_pkg::ADDR_U_BLK:     u_blk     <= wdata_i[15:0];
        seq_stage_pkg::ADDR_DEF_DELAY: def_delay <= wdata_i[OPW-1:0];
        seq_stage_pkg::ADDR_DIAL_K:    dial_k    <= wdata_i[12:0];
        seq_stage_pkg::ADDR_EXP_A:     exp_a     <= wdata_i[11:0];
        seq_stage_pkg::ADDR_REL_DELAY: rel_delay <= wdata_i[14:0];
        default: ;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // inverse time calculation, one pass per program cycle
  // ---------------------------------------------------------------
  calc_state_e    cstate;
  logic [31:0]    div_num;
  logic [31:0]    div_den;
  logic [31:0]    div_rem;
  logic [4:0]     div_cnt;
  logic [31:0]    ratio;
  logic [31:0]    pow;
  logic [4:0]     pow_n;
  logic [OPW-1:0] inv_cycles;
  logic [32:0]    rem_sh;
  logic           div_bit;
  logic [31:0]    rem_nx;
  logic [31:0]    quot;
  logic [31:0]    p_frac;
  logic [31:0]    denom;
  logic           denom_ok;

  assign rem_sh   = {div_rem, div_num[31]};
  assign div_bit  = rem_sh >= {1'b0, div_den};
  assign rem_nx   = div_bit ? 32'(rem_sh - {1'b0, div_den}) : rem_sh[31:0];
  assign quot     = {div_num[30:0], div_bit};
  assign p_frac   = frac_adj(pow, ratio, 7'(exp_a % seq_stage_pkg::EXP_UNIT));
  assign denom    = cfg_under ? 32'(seq_stage_pkg::FX_ONE - p_frac) : 32'(p_frac - seq_stage_pkg::FX_ONE);
  assign denom_ok = cfg_under ? (p_frac < seq_stage_pkg::FX_ONE) : (p_frac > seq_stage_pkg::FX_ONE);

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      cstate     <= C_IDLE;
      div_num    <= 32'h0;
      div_den    <= 32'h0;
      div_rem    <= 32'h0;
      div_cnt    <= 5'h0;
      ratio      <= 32'h0;
      pow        <= 32'h0;
      pow_n      <= 5'h0;
      inv_cycles <= seq_stage_pkg::OP_MAX;
    end else begin
      unique case (cstate)
        C_IDLE: begin
          if (tick) begin
            div_num <= {meas_i, 16'h0};
            div_den <= {16'h0, u_set};
            div_rem <= 32'h0;
            div_cnt <= 5'h0;
            cstate  <= C_RATIO;
          end
        end
        C_RATIO, C_DIV: begin
          div_num <= quot;
          div_rem <= rem_nx;
          div_cnt <= 5'(div_cnt + 1'b1);
          if (div_cnt == 5'h1f) begin
            if (cstate == C_RATIO) begin
              ratio  <= quot;
              pow    <= seq_stage_pkg::FX_ONE;
              pow_n  <= 5'(exp_a / seq_stage_pkg::EXP_UNIT);
              cstate <= C_POW;
            end else begin
              inv_cycles <= (quot > 32'(seq_stage_pkg::OP_MAX)) ? seq_stage_pkg::OP_MAX : quot[OPW-1:0];
              cstate     <= C_IDLE;
            end
          end
        end
        C_POW: begin
          if (pow_n != 5'h0) begin
            pow   <= sat_mul(pow, ratio);
            pow_n <= 5'(pow_n - 1'b1);
          end else if (denom_ok) begin
            div_num <= 32'((32'(dial_k) * 32'(seq_stage_pkg::K_CYCLES_UNIT)) << 16);
            div_den <= denom;
            div_rem <= 32'h0;
            div_cnt <= 5'h0;
            cstate  <= C_DIV;
          end else begin
            inv_cycles <= seq_stage_pkg::OP_MAX;
            cstate     <= C_IDLE;
          end
        end
      endcase
    end
  end

  // ---------------------------------------------------------------
  // decision, evaluated from the inputs as they stand at the tick
  // ---------------------------------------------------------------
  logic           pickup;
  logic           ublk;
  logic           releasing;
  logic [OPW-1:0] op_cnt;
  logic [14:0]    rel_cnt;
  logic [OPW-1:0] target;
  logic           rel_used;
  logic           rel_last;
  logic           next_pickup;
  logic           next_ublk;
  logic           next_pu_eff;
  logic           next_start;
  logic           next_trip;
  logic           next_releasing;
  logic [OPW-1:0] next_op;
  logic [14:0]    next_rel;

  assign target   = cfg_inverse ? inv_cycles : def_delay;
  assign rel_used = (cfg_delayed || cfg_rst_after) && (rel_delay != 15'h0);
  assign rel_last = 16'(rel_cnt + 1'b1) >= 16'(rel_delay);

  always_comb begin
    if (!cfg_under) begin
      next_pickup = pickup ? (scaled(meas_i, seq_stage_pkg::PCT_FULL) >= scaled(u_set, seq_stage_pkg::PCT_OVER_DRP))
                           : (meas_i > u_set);
    end else begin
      next_pickup = pickup ? (scaled(meas_i, seq_stage_pkg::PCT_FULL) <= scaled(u_set, seq_stage_pkg::PCT_UNDR_DRP))
                           : (meas_i < u_set);
    end
    if (!cfg_under || u_blk == 16'h0) begin
      next_ublk = 1'b0;
    end else if (ublk) begin
      next_ublk = !(min_line_i > u_set);
    end else begin
      next_ublk = meas_i < u_blk;
    end
    next_pu_eff = next_pickup && !block_i;
  end

  always_comb begin
    next_start     = start_o;
    next_trip      = trip_o;
    next_releasing = releasing;
    next_op        = op_cnt;
    next_rel       = rel_cnt;
    if (next_pu_eff) begin
      next_start     = 1'b1;
      next_releasing = 1'b0;
      next_rel       = 15'h0;
      next_op        = sat_inc(op_cnt);
      next_trip      = (op_cnt >= target) && !next_ublk;
    end else if (start_o || releasing) begin
      next_trip = 1'b0;
      if (!rel_used) begin
        next_start     = 1'b0;
        next_releasing = 1'b0;
        next_op        = '0;
        next_rel       = 15'h0;
      end else begin
        next_rel       = 15'(rel_cnt + 1'b1);
        next_releasing = !rel_last;
        next_start     = cfg_delayed && !rel_last;
        if (rel_last || !cfg_rst_after) begin
          next_op  = '0;
          next_rel = rel_last ? 15'h0 : next_rel;
        end else if (cfg_continue) begin
          next_op = sat_inc(op_cnt);
        end
      end
    end else begin
      next_start = 1'b0;
      next_trip  = 1'b0;
      next_op    = '0;
    end
  end

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      pickup    <= 1'b0;
      ublk      <= 1'b0;
      releasing <= 1'b0;
      op_cnt    <= '0;
      rel_cnt   <= 15'h0;
      start_o   <= 1'b0;
      trip_o    <= 1'b0;
      blocked_o <= 1'b0;
    end else if (tick) begin
      pickup    <= next_pickup;
      ublk      <= next_ublk;
      releasing <= next_releasing;
      op_cnt    <= next_op;
      rel_cnt   <= next_rel;
      start_o   <= next_start;
      trip_o    <= next_trip;
      blocked_o <= next_pickup && block_i;
    end
  end

  // ---------------------------------------------------------------
  // register read port
  // ---------------------------------------------------------------
  logic [31:0] rd_val;
  logic [31:0] remaining;

  assign remaining = 32'(signed'(33'(target)) - signed'(33'(op_cnt)));

  always_comb begin
    rd_val = 32'h0;
    case (addr_i)
      seq_stage_pkg::ADDR_CTRL: begin
        rd_val[seq_stage_pkg::CTRL_UNDER_BIT]    = cfg_under;
        rd_val[seq_stage_pkg::CTRL_INVERSE_BIT]  = cfg_inverse;
        rd_val[seq_stage_pkg::CTRL_DLY_REL_BIT]  = cfg_delayed;
        rd_val[seq_stage_pkg::CTRL_RST_AFT_BIT]  = cfg_rst_after;
        rd_val[seq_stage_pkg::CTRL_CONTINUE_BIT] = cfg_continue;
      end
      seq_stage_pkg::ADDR_U_SET:     rd_val = 32'(u_set);
      seq_stage_pkg::ADDR_U_BLK:     rd_val = 32'(u_blk);
      seq_stage_pkg::ADDR_DEF_DELAY: rd_val = 32'(def_delay);
      seq_stage_pkg::ADDR_DIAL_K:    rd_val = 32'(dial_k);
      seq_stage_pkg::ADDR_EXP_A:     rd_val = 32'(exp_a);
      seq_stage_pkg::ADDR_REL_DELAY: rd_val = 32'(rel_delay);
      seq_stage_pkg::ADDR_STATUS:    rd_val = {26'h0, releasing, ublk, pickup, blocked_o, trip_o, start_o};
      seq_stage_pkg::ADDR_EXPECTED:  rd_val = 32'(target);
      seq_stage_pkg::ADDR_REMAINING: rd_val = remaining;
      default:                       rd_val = 32'h0;
    endcase
  end

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      rdata_o <= 32'h0;
    end else begin
      rdata_o <= rd_i ? rd_val : 32'h0;
    end
  end

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (rst_i);

  sequence s_free_pickup;
    tick && next_pickup && !block_i;
  endsequence

  sequence s_blocked_pickup;
    tick && next_pickup && block_i;
  endsequence

  property p_start_on_pickup;
    s_free_pickup |=> start_o;
  endproperty
  a_start_on_pickup: assert property (p_start_on_pickup) else $error("start missing after free pick-up");

  property p_instant;
    s_free_pickup ##0 (target == '0 && !next_ublk) |=> (trip_o && start_o);
  endproperty
  a_instant: assert property (p_instant) else $error("instant trip not with start");

  property p_blocked;
    s_blocked_pickup |=> (blocked_o && !trip_o);
  endproperty
  a_blocked: assert property (p_blocked) else $error("blocked pick-up not reported or tripped");

  property p_block_resets;
    tick && block_i && start_o && !cfg_delayed |=> !start_o;
  endproperty
  a_block_resets: assert property (p_block_resets) else $error("start kept after blocking");

  property p_ublk_no_trip;
    ublk |-> !trip_o;
  endproperty
  a_ublk_no_trip: assert property (p_ublk_no_trip) else $error("trip during undervoltage block");

  property p_ublk_zero;
    tick && u_blk == 16'h0 |=> !ublk;
  endproperty
  a_ublk_zero: assert property (p_ublk_zero) else $error("undervoltage block with zero level");

  property p_ublk_hold;
    tick && ublk && cfg_under && u_blk != 16'h0 && !(min_line_i > u_set) |=> ublk;
  endproperty
  a_ublk_hold: assert property (p_ublk_hold) else $error("undervoltage block released early");

  property p_stable;
    !tick |=> ($stable(start_o) && $stable(trip_o) && $stable(blocked_o));
  endproperty
  a_stable: assert property (p_stable) else $error("outputs moved between program cycles");

  property p_tick_gap;
    tick |=> !tick [*8];
  endproperty
  a_tick_gap: assert property (p_tick_gap) else $error("program cycle too short");

  property p_release_hold;
    tick && start_o && !next_pu_eff && cfg_delayed && rel_used && !releasing && rel_delay > 15'h1
      |=> (start_o && releasing && !trip_o);
  endproperty
  a_release_hold: assert property (p_release_hold) else $error("start not held in release");

  property p_no_trip_release;
    releasing |-> !trip_o;
  endproperty
  a_no_trip_release: assert property (p_no_trip_release) else $error("trip during release time");

  property p_def_time;
    tick && next_pu_eff && !cfg_inverse && op_cnt < def_delay |=> !trip_o;
  endproperty
  a_def_time: assert property (p_def_time) else $error("fixed delay trip too early");

  property p_over_drop;
    tick && pickup && !cfg_under
      && scaled(meas_i, seq_stage_pkg::PCT_FULL) < scaled(u_set, seq_stage_pkg::PCT_OVER_DRP) |=> !pickup;
  endproperty
  a_over_drop: assert property (p_over_drop) else $error("over pick-up kept below drop level");

endmodule
`default_nettype wire
